//--- hdl/sbrg_gate.sv
`timescale 1ns/1ps
`default_nettype none
module sbrg_gate
  import sbrg_pkg::*;
#(
  parameter logic [4:0] TO_CLKS = SBRG_TO_CLKS
)
(
  input wire logic sys_clk, // pci clock, 10 MHz
  input wire logic resetn, // combined pcie, global and power-on reset
  input wire logic ce, // clock enable
  input wire logic [7:0] cfg_addr, // config byte offset
  input wire logic cfg_wr, // config write strobe
  input wire logic cfg_rd, // config read strobe
  input wire logic [7:0] cfg_wdata, // config write byte
  output logic [7:0] cfg_rdata, // config read byte, one cycle after cfg_rd
  input wire logic [5:0] req_pin_n, // request pins, low active
  input wire logic frame_pin_n, // frame pin, low active
  input wire logic bus_idle, // idle bus from arbiter core
  input wire logic [5:0] gnt, // one-hot grant from arbiter core
  output logic [5:0] req_gated, // requests passed to arbiter core
  output logic grant0_priority_level, // requester 0 tier, 1 = high
  output logic [5:0] timeout_flags, // time-out status per request
  output logic [5:0] timeout_pulse // one-cycle time-out event
);
  localparam sbrg_state_t ST_RST = '{
    gate: SBRG_GATE_RST,
    tier0: SBRG_TIER0_RST,
    flags: SBRG_FLAG_RST,
    cnt: '0,
    gnt_prev: '0,
    to_pulse: '0,
    rdata: '0
  };

  sbrg_state_t st_r;
  sbrg_state_t st_nxt;
  logic [6:0] pin_lvl;
  logic frame_act;
  logic watch_go;

  sbrg_pin_sync #(
    .W(7),
    .RST_VAL(SBRG_PIN_IDLE)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .pin_in({frame_pin_n, req_pin_n}),
    .level_out(pin_lvl)
  );

  assign frame_act = ~pin_lvl[6];
  // idle bus, steady grant, no frame yet
  assign watch_go = bus_idle && !frame_act && (gnt != 6'h00) && (gnt == st_r.gnt_prev);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.to_pulse = 6'h00;
    st_nxt.gnt_prev = gnt;
    if (!watch_go)
      st_nxt.cnt = 5'h00;
    else if (st_r.cnt != TO_CLKS)
    begin
      st_nxt.cnt = 5'(st_r.cnt + 5'h01);
      if ((st_r.cnt == 5'(TO_CLKS - 5'h01)) && st_r.gate[SBRG_BIT_WATCH])
        st_nxt.to_pulse = gnt;
    end
    if (cfg_wr)
    begin
      if (cfg_addr == SBRG_OFF_ARB_CTRL)
        st_nxt.tier0 = cfg_wdata[SBRG_BIT_TIER0];
      if (cfg_addr == SBRG_OFF_REQ_GATE)
        st_nxt.gate = cfg_wdata;
      if (cfg_addr == SBRG_OFF_TO_STAT)
        st_nxt.flags = st_r.flags & ~cfg_wdata[5:0];
    end
    // hardware set beats a same-cycle clear
    st_nxt.flags = st_nxt.flags | st_nxt.to_pulse;
    if (st_r.gate[SBRG_BIT_AUTO])
      st_nxt.gate[5:0] = st_nxt.gate[5:0] | st_nxt.to_pulse;
    if (cfg_rd)
    begin
      unique case (cfg_addr)
        SBRG_OFF_ARB_CTRL: st_nxt.rdata = {7'h00, st_r.tier0};
        SBRG_OFF_REQ_GATE: st_nxt.rdata = st_r.gate;
        SBRG_OFF_TO_STAT: st_nxt.rdata = {2'h0, st_r.flags};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= ST_RST;
    else if (ce)
      st_r <= st_nxt;
  end

  assign req_gated = ~pin_lvl[5:0] & ~st_r.gate[5:0];
  assign grant0_priority_level = st_r.tier0;
  assign timeout_flags = st_r.flags;
  assign timeout_pulse = st_r.to_pulse;
  assign cfg_rdata = st_r.rdata;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_tier;
    ce && cfg_wr && (cfg_addr == SBRG_OFF_ARB_CTRL) |=> grant0_priority_level == $past(cfg_wdata[0]);
  endproperty
  a_tier: assert property (p_tier) else $error("tier bit not written");

  property p_nowatch;
    (timeout_pulse != 6'h00) |-> $past(st_r.gate[SBRG_BIT_WATCH]);
  endproperty
  a_nowatch: assert property (p_nowatch) else $error("time-out while watch off");

  property p_fire;
    ce && watch_go && (st_r.cnt == 5'(TO_CLKS - 5'h01)) && st_r.gate[SBRG_BIT_WATCH]
      |=> timeout_pulse == $past(gnt);
  endproperty
  a_fire: assert property (p_fire) else $error("time-out missed at threshold");

  property p_count;
    (timeout_pulse != 6'h00) |-> $past(st_r.cnt) == 5'(TO_CLKS - 5'h01);
  endproperty
  a_count: assert property (p_count) else $error("time-out at wrong count");

  property p_auto;
    (timeout_pulse != 6'h00) && $past(st_r.gate[SBRG_BIT_AUTO])
      |-> (st_r.gate[5:0] & timeout_pulse) == timeout_pulse;
  endproperty
  a_auto: assert property (p_auto) else $error("auto mask not applied");

  property p_ignore;
    ce && cfg_wr && (cfg_addr == SBRG_OFF_REQ_GATE)
      |=> (req_gated & $past(cfg_wdata[5:0])) == 6'h00;
  endproperty
  a_ignore: assert property (p_ignore) else $error("gated request passed");

  property p_hold;
    ce && st_r.gate[0] && !(cfg_wr && (cfg_addr == SBRG_OFF_REQ_GATE)) |=> st_r.gate[0];
  endproperty
  a_hold: assert property (p_hold) else $error("gate bit dropped by itself");

  property p_flag;
    (timeout_pulse != 6'h00) |-> (timeout_flags & timeout_pulse) == timeout_pulse;
  endproperty
  a_flag: assert property (p_flag) else $error("time-out flag not set");

  property p_tier_keep;
    ce && !(cfg_wr && (cfg_addr == SBRG_OFF_ARB_CTRL)) |=> $stable(grant0_priority_level);
  endproperty
  a_tier_keep: assert property (p_tier_keep) else $error("tier bit moved unasked");

  property p_rd_tier;
    ce && cfg_rd && (cfg_addr == SBRG_OFF_ARB_CTRL)
      |=> cfg_rdata == {7'h00, $past(grant0_priority_level)};
  endproperty
  a_rd_tier: assert property (p_rd_tier) else $error("tier read wrong");

  property p_restart;
    ce && !watch_go |=> st_r.cnt == 5'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("count not restarted");

  property p_sat;
    ce && watch_go && (st_r.cnt == TO_CLKS) |=> st_r.cnt == TO_CLKS;
  endproperty
  a_sat: assert property (p_sat) else $error("count left threshold");

  property p_one_shot;
    ce && (timeout_pulse != 6'h00) |=> timeout_pulse == 6'h00;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("pulse held too long");

  property p_noauto;
    ce && !st_r.gate[SBRG_BIT_AUTO] && !(cfg_wr && (cfg_addr == SBRG_OFF_REQ_GATE))
      |=> st_r.gate[5:0] == $past(st_r.gate[5:0]);
  endproperty
  a_noauto: assert property (p_noauto) else $error("gate moved without write");

  property p_rd_gate;
    ce && cfg_rd && (cfg_addr == SBRG_OFF_REQ_GATE) |=> cfg_rdata == $past(st_r.gate);
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("gate read wrong");

  property p_hold_all;
    ce && !(cfg_wr && (cfg_addr == SBRG_OFF_REQ_GATE))
      |=> (st_r.gate[5:0] & $past(st_r.gate[5:0])) == $past(st_r.gate[5:0]);
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("ignore bit dropped");

  property p_sticky;
    ce && !(cfg_wr && (cfg_addr == SBRG_OFF_TO_STAT))
      |=> (timeout_flags & $past(timeout_flags)) == $past(timeout_flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_clear;
    ce && cfg_wr && (cfg_addr == SBRG_OFF_TO_STAT)
      |=> (timeout_flags & $past(cfg_wdata[5:0]) & ~timeout_pulse) == 6'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_rd_flags;
    ce && cfg_rd && (cfg_addr == SBRG_OFF_TO_STAT)
      |=> cfg_rdata == {2'h0, $past(timeout_flags)};
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read wrong");
endmodule
`default_nettype wire

//--- hdl/sbrg_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sbrg_pin_sync
  import sbrg_pkg::*;
#(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '1
)
(
  input wire logic sys_clk, // pci clock
  input wire logic resetn, // async reset, low active
  input wire logic ce, // clock enable
  input wire logic [W-1:0] pin_in, // raw pin levels
  output logic [W-1:0] level_out // filtered level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sbrg_sync_st_t;

  sbrg_sync_st_t st_r;
  sbrg_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++)
    begin
      // change accepted once stages two and three agree
      if (st_r.s2[i] == st_r.s3[i])
        st_nxt.q[i] = st_r.s3[i];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    else if (ce)
      st_r <= st_nxt;
  end

  assign level_out = st_r.q;
endmodule
`default_nettype wire

//--- hdl/sbrg_pkg.sv
package sbrg_pkg;
  localparam int SBRG_NUM_REQ = 6;
  localparam int SBRG_CNT_W = 5;
  localparam logic [7:0] SBRG_OFF_ARB_CTRL = 8'hdc;
  localparam logic [7:0] SBRG_OFF_REQ_GATE = 8'hdd;
  localparam logic [7:0] SBRG_OFF_TO_STAT = 8'hde;
  localparam int SBRG_BIT_WATCH = 7;
  localparam int SBRG_BIT_AUTO = 6;
  localparam int SBRG_BIT_TIER0 = 0;
  localparam logic [7:0] SBRG_GATE_RST = 8'h00;
  localparam logic SBRG_TIER0_RST = 1'b0;
  localparam logic [5:0] SBRG_FLAG_RST = 6'h00;
  localparam logic [4:0] SBRG_TO_CLKS = 5'h10;
  localparam logic [6:0] SBRG_PIN_IDLE = 7'h7f;

  typedef struct packed {
    logic [7:0] gate;
    logic tier0;
    logic [5:0] flags;
    logic [4:0] cnt;
    logic [5:0] gnt_prev;
    logic [5:0] to_pulse;
    logic [7:0] rdata;
  } sbrg_state_t;
endpackage

//--- test/sbrg_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbrg_master_model (
  input wire logic sys_clk, // pci clock
  input wire logic [5:0] want, // masters wanting the bus
  input wire logic [5:0] gnt, // grant seen by masters
  input wire logic prompt, // 1 = answer a grant with frame
  output logic [5:0] req_pin_n, // requests, low active
  output logic frame_pin_n // frame, pulled up when released
);
  always_ff @(posedge sys_clk)
  begin
    req_pin_n <= ~want;
    frame_pin_n <= !(prompt && gnt != 6'h00);
  end
endmodule
`default_nettype wire

//--- test/tb_sbrg_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sbrg_gate;
  import sbrg_pkg::*;
  logic sys_clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, bus_idle = 0, prompt = 0, ce = 1;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, rv;
  logic [5:0] req_pin_n, want = 6'h00, gnt = 6'h00, req_gated, timeout_flags, timeout_pulse;
  logic frame_pin_n, grant0_priority_level;
  logic [31:0] seed = 32'h3331dde2;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  sbrg_gate i_sbrg_gate (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .req_pin_n(req_pin_n), .frame_pin_n(frame_pin_n),
    .bus_idle(bus_idle), .gnt(gnt), .req_gated(req_gated),
    .grant0_priority_level(grant0_priority_level), .timeout_flags(timeout_flags),
    .timeout_pulse(timeout_pulse));
  sbrg_master_model i_sbrg_master_model (.sys_clk(sys_clk), .want(want), .gnt(gnt),
    .prompt(prompt), .req_pin_n(req_pin_n), .frame_pin_n(frame_pin_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] pass_req(input logic [5:0] w, input logic [7:0] m);
    return {2'b00, w & ~m[5:0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    rv = cfg_rdata;
  endtask
  task automatic episode(input int k, input logic [7:0] ctl);
    int n = 0;
    logic [7:0] g = 8'h01 << k;
    logic fire = ctl[7] && !prompt;
    wr(SBRG_OFF_REQ_GATE, ctl);
    gnt = g[5:0];
    bus_idle = 1'b1;
    while (timeout_pulse === 6'h00 && n < 24)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("pulse", fire ? g : 8'h00, {2'b00, timeout_pulse});
    chk("flags", fire ? g : 8'h00, {2'b00, timeout_flags});
    chk("latency", fire ? 8'(SBRG_TO_CLKS + 5'h01) : 8'h18, n[7:0]);
    @(negedge sys_clk);
    chk("pulse_end", 8'h00, {2'b00, timeout_pulse});
    gnt = 6'h00;
    bus_idle = 1'b0;
    rd(SBRG_OFF_REQ_GATE);
    chk("auto_mask", ctl | ((fire && ctl[6]) ? g : 8'h00), rv);
    rd(SBRG_OFF_TO_STAT);
    chk("flag_reg", fire ? g : 8'h00, rv);
    wr(SBRG_OFF_TO_STAT, 8'hff);
    rd(SBRG_OFF_TO_STAT);
    chk("flag_clr", 8'h00, rv);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      conclude;
    end
  end
  initial
  begin
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    rd(SBRG_OFF_ARB_CTRL);
    chk("tier_rst", 8'h00, rv);
    rd(SBRG_OFF_REQ_GATE);
    chk("gate_rst", 8'h00, rv);
    wr(SBRG_OFF_ARB_CTRL, 8'h01);
    chk("tier_hi", 8'h01, {7'h00, grant0_priority_level});
    rd(SBRG_OFF_ARB_CTRL);
    chk("tier_rd", 8'h01, rv);
    ce = 1'b0;
    wr(SBRG_OFF_REQ_GATE, 8'h2a);
    ce = 1'b1;
    rd(SBRG_OFF_REQ_GATE);
    chk("ce_freeze", 8'h00, rv);
    for (int i = 0; i < 20; i++)
    begin
      seed = lfsr(seed);
      wr(SBRG_OFF_REQ_GATE, i == 0 ? 8'h3f : (i == 1 ? 8'h00 : {2'b00, seed[5:0]}));
      want = (i < 2) ? 6'h3f : seed[13:8];
      repeat (5) @(negedge sys_clk);
      chk("req_gated", pass_req(want, cfg_wdata), {2'b00, req_gated});
    end
    want = 6'h00;
    episode(0, 8'h40);
    for (int k = 0; k < 6; k++)
      episode(k, k[0] ? 8'h80 : 8'hc0);
    prompt = 1'b1;
    episode(2, 8'hc0);
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk("tier_rst2", 8'h00, {7'h00, grant0_priority_level});
    resetn = 1'b1;
    rd(SBRG_OFF_REQ_GATE);
    chk("gate_rst2", 8'h00, rv);
    conclude;
  end
endmodule
`default_nettype wire
